// [pkg/fs_filter_pkg.sv]
// Constants, types and register map of the fast settling filter
`default_nettype none
package fs_filter_pkg;
    // ----------------------------------------
    // Clock rates and controller clock NCO
    // ----------------------------------------
    localparam longint unsigned CLK_HZ = 64'h0000_0000_05F5_E100;
    localparam longint unsigned F_FULL_HZ = 64'h0000_0000_0009_6000;
    localparam longint unsigned F_MID_HZ = 64'h0000_0000_0002_5800;
    localparam longint unsigned F_LOW_HZ = 64'h0000_0000_0001_2C00;
    localparam logic [31:0] INC_FULL = 32'((F_FULL_HZ << 32) / CLK_HZ);
    localparam logic [31:0] INC_MID = 32'((F_MID_HZ << 32) / CLK_HZ);
    localparam logic [31:0] INC_LOW = 32'((F_LOW_HZ << 32) / CLK_HZ);
    // ----------------------------------------
    // Filter figures
    // ----------------------------------------
    localparam int unsigned RES_W = 32'h0000_0040;
    localparam int unsigned SUM_W = 32'h0000_0044;
    localparam int unsigned CH_W = 32'h0000_0004;
    localparam int unsigned SINC_STAGES = 32'h0000_0004;
    localparam logic [2:0] ORDER4 = 3'h4;
    localparam logic [2:0] ORDER3 = 3'h3;
    localparam logic [3:0] AVG_LAST_HI = 4'hF;
    localparam logic [3:0] AVG_LAST_LOW = 4'h7;
    localparam int unsigned AVG_SHIFT_HI = 32'h0000_0004;
    localparam int unsigned AVG_SHIFT_LOW = 32'h0000_0003;
    localparam int unsigned DECIM_SHIFT = 32'h0000_0005;
    localparam logic [6:0] DEAD_MANUAL = 7'h5F;
    localparam logic [6:0] DEAD_SEQ = 7'h1E;
    localparam logic [10:0] FS_MIN = 11'h001;
    // ----------------------------------------
    // Register map and fields
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CHAN_EN = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RES_LO = 8'h0C;
    localparam logic [7:0] REG_RES_HI = 8'h10;
    localparam logic [7:0] REG_RES_CH = 8'h14;
    localparam int unsigned CTRL_PWR_LSB = 32'h0000_0000;
    localparam int unsigned CTRL_FT_LSB = 32'h0000_0002;
    localparam int unsigned CTRL_FS_LSB = 32'h0000_0010;
    localparam int unsigned ST_AVAIL_BIT = 32'h0000_0000;
    localparam int unsigned ST_STALL_BIT = 32'h0000_0001;
    localparam int unsigned ST_STATE_LSB = 32'h0000_0002;
    localparam int unsigned ST_CHAN_LSB = 32'h0000_0008;
    localparam int unsigned ST_COUNT_LSB = 32'h0000_0010;
    localparam logic [1:0] PWR_LOW = 2'h0;
    localparam logic [1:0] PWR_MID = 2'h1;
    localparam logic [1:0] PWR_FULL = 2'h2;
    localparam logic [2:0] FT_FAST_SINC4 = 3'h4;
    localparam logic [2:0] FT_FAST_SINC3 = 3'h5;
    localparam logic [2:0] FT_RESET = 3'h0;
    localparam logic [10:0] FS_RESET = 11'h018;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DEAD = 3'b010,
        ST_CONV = 3'b100
    } conv_state_e;
    typedef struct packed {
        logic [CH_W-1:0]  chan;
        logic [RES_W-1:0] value;
    } result_s;
endpackage : fs_filter_pkg
`default_nettype wire

// [rtl/result_fifo.sv]
// Result FIFO with registered read data
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
    parameter int unsigned WIDTH = 68,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    // Depth must be a power of two, pointers wrap freely
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             out_valid_r;
    logic [WIDTH-1:0] out_data_r;

    wire push = in_valid & in_ready;
    wire load = (count_r != '0) & (~out_valid_r | out_ready);

    assign in_ready  = count_r < (AW+1)'(DEPTH);
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (load) begin
            out_data_r <= mem_r[rd_ptr_r];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            out_valid_r <= 1'b0;
        end else begin
            wr_ptr_r    <= wr_ptr_r + AW'(push);
            rd_ptr_r    <= rd_ptr_r + AW'(load);
            count_r     <= count_r + (AW+1)'(push) - (AW+1)'(load);
            out_valid_r <= load | (out_valid_r & ~out_ready);
        end
    end
endmodule : result_fifo
`default_nettype wire

// [rtl/fs_sinc_avg_filter.sv]
// Fast settling sinc plus averaging decimation path with sequencer timing
//
// What this block does
// - Filter type bits select the fast settling path, a sinc stage then an averaging stage.
// - The averaging stage sums 16 sinc results in full and mid power, 8 in low power.
// - On one channel a result comes every average count times 32 times the rate field ticks.
// - The controller tick runs at 614.4 kHz, 153.6 kHz or 76.8 kHz by power mode.
// - After a manual change the first result takes (order+avg-1)*32*rate plus 95 ticks.
// - With several channels enabled the block steps through them, first with full settling.
// - Each later sequenced conversion settles fully but with 30 ticks of dead time.
// - A step on one channel is not detected and results keep coming.
// - Results come at a near constant rate across channel changes.
// - The sinc notch sits at tick rate over 32 times rate, averaging adds notches below it.
// - A second variant uses a third order sinc stage with the same averaging counts.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fs_sinc_avg_filter #(
    parameter int unsigned NUM_CH     = 16,
    parameter int unsigned FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Modulator side
    input  wire logic        mod_bit,
    output logic [3:0]       mod_chan,
    output logic             mod_restart,
    output logic             ctrl_tick,
    // Status
    output logic             result_avail
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                      mod_sync1_r;
    logic                      mod_sync2_r;
    logic [1:0]                pwr_r;
    logic [2:0]                ftype_r;
    logic [10:0]               fs_r;
    logic [NUM_CH-1:0]         chan_en_r;
    logic [31:0]               nco_r;
    logic                      tick_r;
    fs_filter_pkg::conv_state_e state_r;
    fs_filter_pkg::conv_state_e state_nxt;
    logic [6:0]                dead_r;
    logic [6:0]                dead_nxt;
    logic [15:0]               dec_r;
    logic [1:0]                skip_r;
    logic [3:0]                avg_r;
    logic [fs_filter_pkg::SUM_W-1:0] sum_r;
    logic [3:0]                chan_r;
    fs_filter_pkg::result_s    res_r;
    logic                      res_valid_r;
    logic                      restart_pend_r;
    logic                      stall_seen_r;
    logic [15:0]               res_count_r;
    logic                      restart_out_r;
    logic                      avail_r;
    logic [31:0]               rdata_r;
    logic                      fifo_in_ready;
    logic                      fifo_out_valid;
    fs_filter_pkg::result_s    fifo_out;

    function automatic logic [3:0] next_chan(input logic [NUM_CH-1:0] mask, input logic [3:0] cur);
        logic [3:0]  pick;
        logic        found;
        int unsigned idx;
        pick  = cur;
        found = 1'b0;
        for (int unsigned i = 1; i <= NUM_CH; i++) begin
            idx = (32'(cur) + i) % NUM_CH;
            if (!found && mask[idx]) begin
                pick  = 4'(idx);
                found = 1'b1;
            end
        end
        return pick;
    endfunction : next_chan

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    wire sel_ctrl   = reg_addr == fs_filter_pkg::REG_CTRL;
    wire sel_chen   = reg_addr == fs_filter_pkg::REG_CHAN_EN;
    wire sel_status = reg_addr == fs_filter_pkg::REG_STATUS;
    wire sel_res_lo = reg_addr == fs_filter_pkg::REG_RES_LO;
    wire sel_res_hi = reg_addr == fs_filter_pkg::REG_RES_HI;
    wire sel_res_ch = reg_addr == fs_filter_pkg::REG_RES_CH;
    wire cfg_wr     = reg_wr & (sel_ctrl | sel_chen);
    wire fifo_pop   = reg_rd & sel_res_hi;
    wire stat_rd    = reg_rd & sel_status;

    wire [31:0] nco_inc = (pwr_r == fs_filter_pkg::PWR_LOW) ? fs_filter_pkg::INC_LOW :
                          (pwr_r == fs_filter_pkg::PWR_MID) ? fs_filter_pkg::INC_MID :
                          fs_filter_pkg::INC_FULL;
    wire [32:0] nco_sum = {1'b0, nco_r} + {1'b0, nco_inc};

    // only the two fast settling codes run the path
    wire is_sinc3 = ftype_r == fs_filter_pkg::FT_FAST_SINC3;
    wire path_on  = (ftype_r == fs_filter_pkg::FT_FAST_SINC4 | is_sinc3) & (|chan_en_r);
    wire [2:0] order = is_sinc3 ? fs_filter_pkg::ORDER3 : fs_filter_pkg::ORDER4;
    wire       low_pwr  = pwr_r == fs_filter_pkg::PWR_LOW;
    wire [3:0] avg_last = low_pwr ? fs_filter_pkg::AVG_LAST_LOW : fs_filter_pkg::AVG_LAST_HI;
    // a zero rate field would underflow the divider, treat it as one
    wire [10:0] fs_eff = (fs_r == '0) ? fs_filter_pkg::FS_MIN : fs_r;
    // decimation of 32 times rate sets the sinc notch
    wire [15:0] dec_reload = ({5'h00, fs_eff} << fs_filter_pkg::DECIM_SHIFT) - 16'h0001;
    wire multi_ch = |(chan_en_r & (chan_en_r - NUM_CH'(1)));

    // Full FIFO with a result waiting freezes the whole path
    wire stall    = res_valid_r & ~fifo_in_ready;
    wire run      = tick_r & ~stall;
    wire in_conv  = state_r == fs_filter_pkg::ST_CONV;
    wire conv_run = run & in_conv;
    wire sinc_evt = conv_run & (dec_r == '0);
    wire take     = sinc_evt & (skip_r == '0);
    wire res_evt  = take & (avg_r == avg_last);
    // with several channels enabled, step to the next enabled channel after each result
    wire seq_step = res_evt & multi_ch;
    wire restart  = path_on & (restart_pend_r | state_r == fs_filter_pkg::ST_IDLE);

    wire [3:0] first_ch = next_chan(chan_en_r, 4'(NUM_CH - 1));
    wire [3:0] step_ch  = next_chan(chan_en_r, chan_r);

    // ----------------------------------------
    // Sinc stage
    // ----------------------------------------
    wire [fs_filter_pkg::RES_W-1:0] integ_in [fs_filter_pkg::SINC_STAGES];
    wire [fs_filter_pkg::RES_W-1:0] comb_in  [fs_filter_pkg::SINC_STAGES];
    wire [fs_filter_pkg::RES_W-1:0] comb_out [fs_filter_pkg::SINC_STAGES];
    logic [fs_filter_pkg::RES_W-1:0] integ_r [fs_filter_pkg::SINC_STAGES];
    logic [fs_filter_pkg::RES_W-1:0] dly_r   [fs_filter_pkg::SINC_STAGES];
    // Comb takes the top integrator as it updates, else the first kept output straddles the start
    wire [fs_filter_pkg::RES_W-1:0] integ_top = is_sinc3 ?
        integ_r[fs_filter_pkg::SINC_STAGES-2] + integ_r[fs_filter_pkg::SINC_STAGES-3] :
        integ_r[fs_filter_pkg::SINC_STAGES-1] + integ_r[fs_filter_pkg::SINC_STAGES-2];

    // Third order leaves the last integrator and last comb as plain passes
    for (genvar k = 0; k < fs_filter_pkg::SINC_STAGES; k++) begin : g_stage
        wire int_on  = 3'(k) < order;
        wire comb_on = 3'(k) < order;
        if (k == 0) begin : g_first
            assign integ_in[k] = fs_filter_pkg::RES_W'(mod_sync2_r);
            assign comb_in[k]  = integ_top;
        end else begin : g_next
            assign integ_in[k] = integ_r[k-1];
            assign comb_in[k]  = comb_out[k-1];
        end
        assign comb_out[k] = comb_on ? comb_in[k] - dly_r[k] : comb_in[k];

        always_ff @(posedge clk) begin
            if (rst || !in_conv) begin
                integ_r[k] <= '0;
            end else if (conv_run) begin
                integ_r[k] <= int_on ? integ_r[k] + integ_in[k] : integ_in[k];
            end
        end

        always_ff @(posedge clk) begin
            if (rst || !in_conv) begin
                dly_r[k] <= '0;
            end else if (sinc_evt) begin
                dly_r[k] <= comb_in[k];
            end
        end
    end

    wire [fs_filter_pkg::SUM_W-1:0] sum_in = sum_r + 
        fs_filter_pkg::SUM_W'(comb_out[fs_filter_pkg::SINC_STAGES-1]);
    wire [fs_filter_pkg::RES_W-1:0] avg_val = low_pwr ?
        sum_in[fs_filter_pkg::AVG_SHIFT_LOW +: fs_filter_pkg::RES_W] :
        sum_in[fs_filter_pkg::AVG_SHIFT_HI +: fs_filter_pkg::RES_W];

    // ----------------------------------------
    // Sequencer state machine
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        dead_nxt  = dead_r;
        if (!path_on) begin
            state_nxt = fs_filter_pkg::ST_IDLE;
        end else if (restart) begin
            // manual change pays the long dead time
            state_nxt = fs_filter_pkg::ST_DEAD;
            dead_nxt  = fs_filter_pkg::DEAD_MANUAL;
        end else begin
            case (state_r)
                fs_filter_pkg::ST_DEAD: begin
                    if (run) begin
                        if (dead_r == 7'h01) begin
                            state_nxt = fs_filter_pkg::ST_CONV;
                        end else begin
                            dead_nxt = dead_r - 7'h01;
                        end
                    end
                end
                fs_filter_pkg::ST_CONV: begin
                    // sequenced step pays the short dead time
                    if (seq_step) begin
                        state_nxt = fs_filter_pkg::ST_DEAD;
                        dead_nxt  = fs_filter_pkg::DEAD_SEQ;
                    end
                end
                default: begin
                    state_nxt = fs_filter_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= fs_filter_pkg::ST_IDLE;
            dead_r  <= '0;
        end else begin
            state_r <= state_nxt;
            dead_r  <= dead_nxt;
        end
    end

    // ----------------------------------------
    // Conversion counters
    // ----------------------------------------
    // counters reload whenever the path leaves conversion
    always_ff @(posedge clk) begin
        if (rst || !in_conv) begin
            dec_r  <= dec_reload;
            skip_r <= 2'(order - 3'h1);
            avg_r  <= '0;
            sum_r  <= '0;
        end else if (sinc_evt) begin
            // one sinc result per 32 times rate ticks
            dec_r <= dec_reload;
            if (skip_r != '0) begin
                // unsettled sinc outputs after reset are dropped
                skip_r <= skip_r - 2'h1;
            end else if (res_evt) begin
                // no step detection, averaging simply continues
                avg_r <= '0;
                sum_r <= '0;
            end else begin
                // block average of successive sinc results
                avg_r <= avg_r + 4'h1;
                sum_r <= sum_in;
            end
        end else if (conv_run) begin
            dec_r <= dec_r - 16'h0001;
        end
    end

    // ----------------------------------------
    // Channel, result and tick
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_r <= '0;
        end else if (restart) begin
            chan_r <= first_ch;
        end else if (seq_step) begin
            chan_r <= step_ch;
        end
    end

    always_ff @(posedge clk) begin
        if (res_evt) begin
            res_r.chan  <= chan_r;
            res_r.value <= avg_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            res_valid_r   <= 1'b0;
            res_count_r   <= '0;
            restart_out_r <= 1'b0;
            nco_r         <= '0;
            tick_r        <= 1'b0;
            mod_sync1_r   <= 1'b0;
            mod_sync2_r   <= 1'b0;
            avail_r       <= 1'b0;
        end else begin
            // results leave at the averaging rate
            res_valid_r   <= res_evt | (res_valid_r & ~fifo_in_ready);
            res_count_r   <= res_count_r + 16'(res_evt);
            restart_out_r <= restart | seq_step;
            nco_r         <= nco_sum[31:0];
            tick_r        <= nco_sum[32];
            mod_sync1_r   <= mod_bit;
            mod_sync2_r   <= mod_sync1_r;
            avail_r       <= fifo_out_valid;
        end
    end

    result_fifo #(
        .WIDTH ($bits(fs_filter_pkg::result_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (res_valid_r),
        .in_data   (res_r),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out),
        .out_ready (fifo_pop)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_r     <= fs_filter_pkg::PWR_FULL;
            ftype_r   <= fs_filter_pkg::FT_RESET;
            fs_r      <= fs_filter_pkg::FS_RESET;
            chan_en_r <= NUM_CH'(1);
        end else if (reg_wr && sel_ctrl) begin
            pwr_r   <= reg_wdata[fs_filter_pkg::CTRL_PWR_LSB +: 2];
            ftype_r <= reg_wdata[fs_filter_pkg::CTRL_FT_LSB +: 3];
            fs_r    <= reg_wdata[fs_filter_pkg::CTRL_FS_LSB +: 11];
        end else if (reg_wr && sel_chen) begin
            chan_en_r <= reg_wdata[NUM_CH-1:0];
        end
    end

    // A stall seen while reading status still sticks
    always_ff @(posedge clk) begin
        if (rst) begin
            restart_pend_r <= 1'b0;
            stall_seen_r   <= 1'b0;
        end else begin
            restart_pend_r <= cfg_wr;
            stall_seen_r   <= (tick_r & stall) | (stall_seen_r & ~stat_rd);
        end
    end

    wire [31:0] ctrl_rd = (32'(fs_r) << fs_filter_pkg::CTRL_FS_LSB) |
                          (32'(ftype_r) << fs_filter_pkg::CTRL_FT_LSB) |
                          (32'(pwr_r) << fs_filter_pkg::CTRL_PWR_LSB);
    wire [31:0] status_rd = (32'(res_count_r) << fs_filter_pkg::ST_COUNT_LSB) |
                            (32'(chan_r) << fs_filter_pkg::ST_CHAN_LSB) |
                            (32'(state_r) << fs_filter_pkg::ST_STATE_LSB) |
                            (32'(stall_seen_r) << fs_filter_pkg::ST_STALL_BIT) |
                            (32'(fifo_out_valid) << fs_filter_pkg::ST_AVAIL_BIT);
    wire [31:0] rd_mux = sel_ctrl   ? ctrl_rd :
                         sel_chen   ? 32'(chan_en_r) :
                         sel_status ? status_rd :
                         sel_res_lo ? fifo_out.value[31:0] :
                         sel_res_hi ? fifo_out.value[63:32] :
                         sel_res_ch ? 32'(fifo_out.chan) : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata    = rdata_r;
    assign mod_chan     = chan_r;
    assign mod_restart  = restart_out_r;
    assign ctrl_tick    = tick_r;
    assign result_avail = avail_r;
endmodule : fs_sinc_avg_filter
`default_nettype wire

// [test/fs_modulator_model.sv]
// Behavioural modulator: one bit per controller tick
`timescale 1ns/1ns
`default_nettype none
module fs_modulator_model (
    // Clock and tick
    input  wire logic clk,
    input  wire logic ctrl_tick,
    // Level to emit
    input  wire logic level,
    output var logic  mod_bit
);
    initial mod_bit = 1'b0;
    // New bit only on a tick, as the real loop would
    always @(posedge clk) begin
        if (ctrl_tick) mod_bit <= level;
    end
endmodule : fs_modulator_model
`default_nettype wire

// [test/fs_filter_sva.sv]
// Port checker for the fast settling filter
`timescale 1ns/1ns
`default_nettype none
module fs_filter_sva (
    // Clock, reset, register port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Modulator side and status
    input wire logic        mod_bit,
    input wire logic [3:0]  mod_chan,
    input wire logic        mod_restart,
    input wire logic        ctrl_tick,
    input wire logic        result_avail
);
    logic        en_r;
    logic [10:0] gap_r;
    wire ctrl_wr = reg_wr && reg_addr == fs_filter_pkg::REG_CTRL;
    wire mask_wr = reg_wr && reg_addr == fs_filter_pkg::REG_CHAN_EN && reg_wdata[15:0] != 16'h0000;
    always_ff @(posedge clk) begin
        en_r <= rst ? 1'b0 : (ctrl_wr ? reg_wdata[4:3] == 2'b10 : en_r);
        gap_r <= (rst || ctrl_tick) ? 11'h000 : gap_r + 11'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_tick_pulse: assert property (ctrl_tick |=> !ctrl_tick [*8])
        else $error("tick pulses too close");
    a_tick_gap: assert property (gap_r <= 11'h517)
        else $error("tick gap too long");
    a_restart_pulse: assert property (mod_restart |=> !mod_restart)
        else $error("restart longer than one cycle");
    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data without read");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_chan_hold: assert property ($changed(mod_chan) |-> (mod_restart || $past(mod_restart)) or ##1 mod_restart)
        else $error("channel moved without restart");
    a_mask_restart: assert property (en_r && mask_wr |-> ##2 mod_restart)
        else $error("no restart after mask write");
    a_idle_quiet: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> !mod_restart)
        else $error("restart while path off");
    a_avail_pop: assert property ($fell(result_avail) |-> $past(reg_rd) || $past(reg_rd, 2) || $past(reg_rd, 3))
        else $error("result lost without pop");
endmodule : fs_filter_sva
`default_nettype wire

// [test/fs_sinc_avg_filter_tb.sv]
// Self-checking bench for the fast settling filter
`timescale 1ns/1ns
`default_nettype none
module fs_sinc_avg_filter_tb;
    logic        clk, rst, reg_wr, reg_rd, mod_bit, mod_restart, ctrl_tick, result_avail;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0]  mod_chan;
    logic [31:0] per [3] = '{32'h0000_0516, 32'h0000_028B, 32'h0000_00A2};
    logic [31:0] fsv [3] = '{32'h001E_0000, 32'h0005_0000, 32'h0018_0000};
    int          n_mismatch, total_checks, n, t;
    fs_sinc_avg_filter u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_chan(mod_chan),
        .mod_restart(mod_restart), .ctrl_tick(ctrl_tick), .result_avail(result_avail));
    fs_modulator_model u_mod (.clk(clk), .ctrl_tick(ctrl_tick), .level(1'b1), .mod_bit(mod_bit));
    always #5 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd
    // Waits on tick (0), restart (1) or result (2); counts ticks meanwhile
    task automatic wait_sig(input int which, input int lim, output int cyc);
        logic s;
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
            s = (which == 0) ? ctrl_tick : ((which == 1) ? mod_restart : result_avail);
            if (ctrl_tick === 1'b1) t++;
        end while (s !== 1'b1 && cyc < lim);
        if (s !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH wait %0d expected 1 seen %b", which, s);
            final_report();
        end
    endtask : wait_sig
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(fs_filter_pkg::REG_CTRL, 32'h0018_0002, "ctrl");
        rd(fs_filter_pkg::REG_CHAN_EN, 32'h0000_0001, "chan_en");
        rd(fs_filter_pkg::REG_STATUS, 32'h0000_0004, "status");
        rd(8'h20, 32'h0000_0000, "unmapped");
        $display("test reset_values done");
        // Low, mid, full power; the rate is not a whole cycle count
        for (int m = 0; m < 3; m++) begin
            wr(fs_filter_pkg::REG_CTRL, fsv[m] | 32'(m));
            wait_sig(0, 3000, n);
            wait_sig(0, 3000, n);
            chk("tick period", per[m], (32'(n) == per[m] + 32'h0000_0001) ? per[m] : 32'(n));
            rd(fs_filter_pkg::REG_CTRL, fsv[m] | 32'(m), "ctrl rate");
        end
        $display("test tick_rates done");
        wr(fs_filter_pkg::REG_CHAN_EN, 32'h0000_000C);
        wr(fs_filter_pkg::REG_CTRL, 32'h0001_0016);
        wait_sig(1, 20, n);
        // A tick beside the restart pulse is already dead time
        t = int'(ctrl_tick === 1'b1);
        chk("first chan", 32'h0000_0002, {28'h000_0000, mod_chan});
        wait_sig(2, 120000, n);
        // Third order, average 16, rate 1: 95 + 18 * 32 ticks
        chk("settle ticks", 32'h0000_029F, 32'(t));
        repeat (10) @(negedge clk);
        chk("next chan", 32'h0000_0003, {28'h000_0000, mod_chan});
        rd(fs_filter_pkg::REG_RES_LO, 32'h0000_8000, "result lo");
        rd(fs_filter_pkg::REG_RES_CH, 32'h0000_0002, "result chan");
        rd(fs_filter_pkg::REG_RES_HI, 32'h0000_0000, "result hi");
        rd(fs_filter_pkg::REG_STATUS, 32'h0001_0308, "status");
        // Manual mask change restarts on the lowest enabled channel
        wr(fs_filter_pkg::REG_CHAN_EN, 32'h0000_0001);
        wait_sig(1, 20, n);
        chk("manual chan", 32'h0000_0000, {28'h000_0000, mod_chan});
        $display("test conversion done");
        final_report();
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
endmodule : fs_sinc_avg_filter_tb
bind fs_sinc_avg_filter fs_filter_sva u_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_chan(mod_chan),
    .mod_restart(mod_restart), .ctrl_tick(ctrl_tick), .result_avail(result_avail));
`default_nettype wire
